/* hdl/nvm_access_pkg.sv */
package nvm_access_pkg;

    // address map and geometry
    localparam int          ADDR_W        = 32;
    localparam int          PAGE_BYTES    = 64;
    localparam int          SECT_W        = 64;
    localparam int          REGION_COUNT  = 16;
    localparam logic [31:0] RWW_BASE      = 32'h0040_0000;
    localparam logic [31:0] RWW_SIZE      = 32'h0000_2000;
    localparam logic [31:0] PBUF_BASE     = 32'h0080_0000;
    localparam logic [31:0] MAIN_SIZE     = 32'h0001_0000;
    localparam logic [63:0] HOLD_RESET    = 64'hffff_ffff_ffff_ffff;
    localparam logic [31:0] SECT_RESET    = 32'h0000_0000;

    // ahb encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
    localparam logic [2:0]  HSIZE_HALF    = 3'h1;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    // read wait states (normal and word-stretched)
    localparam logic [1:0]  READ_WAIT     = 2'h1;
    localparam logic [1:0]  READ_WAIT_W   = 2'h3;

    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_ERASE_ROW = 3'h1,
        CMD_RWW_ERASE = 3'h2,
        CMD_WRITE_PG  = 3'h3,
        CMD_RWW_WRITE = 3'h4,
        CMD_CHIP_ERA  = 3'h5
    } nvm_cmd_t;

    typedef struct packed {
        logic        sel;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ahb_req_t;

    typedef struct packed {
        logic        ready;
        logic        resp;
        logic [31:0] rdata;
    } ahb_rsp_t;

    typedef struct packed {
        logic        valid;
        nvm_cmd_t    cmd;
        logic [31:0] addr;
    } nvm_cmd_req_t;

endpackage

/* hdl/page_buffer_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// page-sized buffer written one 64-bit section at a time, registered read
module page_buffer_mem #(
    parameter int SECTIONS = 8
) (
    input  wire logic                        ref_clk,
    input  wire logic                        wr_en,
    input  wire logic [$clog2(SECTIONS)-1:0] wr_idx,
    input  wire logic [63:0]                 wr_data,
    input  wire logic [$clog2(SECTIONS)-1:0] rd_idx,
    output logic      [63:0]                 rd_data
);
    logic [63:0] mem [SECTIONS];

    initial begin
        if (SECTIONS < 2) $error("page buffer needs two sections or more");
    end

    // one section per write, the rest untouched
    always_ff @(posedge ref_clk) begin
        if (wr_en) mem[wr_idx] <= wr_data;
        rd_data <= mem[rd_idx];
    end
endmodule
`default_nettype wire

/* hdl/nvm_page_buffer_rww_access.sv */
`timescale 1ns/1ns
`default_nettype none
module nvm_page_buffer_rww_access
    import nvm_access_pkg::*;
#(
    parameter int PAGE_SIZE = nvm_access_pkg::PAGE_BYTES,
    parameter int REGIONS   = nvm_access_pkg::REGION_COUNT
) (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire nvm_access_pkg::ahb_req_t    ahb_req,
    output nvm_access_pkg::ahb_rsp_t         ahb_rsp,
    input  wire nvm_access_pkg::nvm_cmd_req_t cmd_req,
    input  wire logic                        debug_chip_erase,
    input  wire logic [REGIONS-1:0]          region_lock,
    input  wire logic                        main_busy,
    input  wire logic                        rww_busy,
    output logic                             rww_rd_en,
    output logic [31:0]                      rww_rd_addr,
    input  wire logic [31:0]                 rww_rd_data,
    output nvm_access_pkg::nvm_cmd_req_t     nvm_cmd,
    output logic                             cmd_locked,
    output logic                             sys_exception,
    output logic [63:0]                      pbuf_rd_data,
    input  wire logic [$clog2(PAGE_SIZE/8)-1:0] pbuf_rd_idx,
    output logic [63:0]                      hold_data
);
    import nvm_access_pkg::*;

    localparam int SECTIONS = PAGE_SIZE / 8;
    localparam int SIDX_W   = $clog2(SECTIONS);
    localparam int RGN_W    = $clog2(REGIONS);
    localparam int RGN_SH   = $clog2(MAIN_SIZE) - RGN_W;

    initial begin
        if (PAGE_SIZE % 8 != 0 || PAGE_SIZE < 16) $error("page size must be 8-byte multiple");
        if (REGIONS < 2) $error("need at least two lock regions");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11
    } rd_state_t;

    // address phase decode
    wire        addr_phase = ahb_req.sel && ahb_req.trans[1] && ahb_rsp.ready;
    wire        hit_rww    = ahb_req.addr >= RWW_BASE && ahb_req.addr < RWW_BASE + RWW_SIZE;
    wire        hit_pbuf   = ahb_req.addr >= PBUF_BASE && ahb_req.addr < PBUF_BASE + MAIN_SIZE;
    wire        rd_rww     = addr_phase && !ahb_req.write && hit_rww;
    wire        wr_pbuf    = addr_phase && ahb_req.write && hit_pbuf;
    wire        wr_byte    = wr_pbuf && ahb_req.size == HSIZE_BYTE;
    wire        rd_blocked = rd_rww && main_busy;
    wire        bad_acc    = wr_byte || rd_blocked;

    // held write address phase (ahb data comes one cycle later)
    logic                    wr_pend_q;
    logic [31:0]             wr_addr_q;
    logic [2:0]              wr_size_q;
    logic [63:0]             hold_q, hold_d;
    logic [31:0]             sect_q;
    logic                    sect_valid_q;

    wire  [31:0] wr_sect    = {wr_addr_q[31:3], 3'h0};
    wire         new_sect   = wr_pend_q && wr_sect != sect_q;
    wire         commit     = new_sect && sect_valid_q;
    wire  [63:0] merge_base = new_sect ? HOLD_RESET : hold_q;
    wire  [1:0]  lane       = wr_addr_q[2:1];
    wire  [SIDX_W-1:0] commit_idx = sect_q[SIDX_W+2:3];

    // lane merge into holding register
    always_comb begin
        hold_d = merge_base;
        if (wr_size_q == HSIZE_WORD) begin
            if (wr_addr_q[2]) hold_d[63:32] = ahb_req.wdata;
            else hold_d[31:0] = ahb_req.wdata;
        end else begin
            hold_d[lane*16 +: 16] = ahb_req.wdata[wr_addr_q[1]*16 +: 16];
        end
    end

    // holding register and tracked section
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend_q    <= 1'b0;
            wr_addr_q    <= 32'h0;
            wr_size_q    <= HSIZE_WORD;
            hold_q       <= HOLD_RESET;
            sect_q       <= SECT_RESET;
            sect_valid_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pbuf && !wr_byte;
            wr_addr_q <= ahb_req.addr - PBUF_BASE;
            wr_size_q <= ahb_req.size;
            if (wr_pend_q) begin
                hold_q       <= hold_d;
                sect_q       <= wr_sect;
                sect_valid_q <= 1'b1;
            end
        end
    end

    page_buffer_mem #(.SECTIONS(SECTIONS)) u_pbuf (
        .ref_clk (ref_clk),
        .wr_en   (commit),
        .wr_idx  (commit_idx),
        .wr_data (hold_q),
        .rd_idx  (pbuf_rd_idx),
        .rd_data (pbuf_rd_data)
    );

    assign hold_data = hold_q;

    // rww read sequencer with stretched word data phase
    rd_state_t   st_q;
    logic [1:0]  wait_q;
    logic [31:0] rdata_q;
    logic        err_q;
    logic        err2_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q    <= ST_IDLE;
            wait_q  <= 2'h0;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
            err2_q  <= 1'b0;
        end else begin
            err_q  <= bad_acc && !err_q;
            err2_q <= err_q;
            unique case (st_q)
                ST_IDLE: if (rd_rww && !rd_blocked) begin
                    st_q   <= ST_WAIT;
                    wait_q <= ahb_req.size == HSIZE_WORD ? READ_WAIT_W : READ_WAIT;
                end
                ST_WAIT: if (wait_q == 2'h0) begin
                    st_q    <= ST_DONE;
                    rdata_q <= rww_rd_data;
                end else begin
                    wait_q  <= wait_q - 2'h1;
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    logic [31:0] rd_addr_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) rd_addr_q <= 32'h0;
        else if (rd_rww) rd_addr_q <= ahb_req.addr - RWW_BASE;
    end

    assign rww_rd_en   = st_q == ST_WAIT;
    assign rww_rd_addr = rd_addr_q;

    // two-cycle error response; ready low only in the first cycle
    wire        rsp_ready = !(st_q == ST_WAIT) && !err_q;
    wire        rsp_err   = err_q || err2_q;
    assign ahb_rsp = '{ready: rsp_ready, resp: rsp_err, rdata: rdata_q}; // one driver for the struct
    assign sys_exception = err_q;

    // command gate: main and rww busy, chip erase and region locks
    wire [RGN_W-1:0] cmd_rgn  = cmd_req.addr[RGN_SH +: RGN_W];
    wire is_main_cmd = cmd_req.cmd == CMD_ERASE_ROW || cmd_req.cmd == CMD_WRITE_PG;
    wire is_rww_cmd  = cmd_req.cmd == CMD_RWW_ERASE || cmd_req.cmd == CMD_RWW_WRITE;
    wire locked_hit  = is_main_cmd && region_lock[cmd_rgn];
    wire busy_hit    = (is_main_cmd && main_busy) || (is_rww_cmd && rww_busy);
    wire cmd_ok      = cmd_req.valid && !locked_hit && !busy_hit;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nvm_cmd    <= '0;
            cmd_locked <= 1'b0;
        end else begin
            cmd_locked <= cmd_req.valid && locked_hit;
            if (debug_chip_erase) begin
                nvm_cmd <= '{valid: 1'b1, cmd: CMD_CHIP_ERA, addr: 32'h0};
            end else begin
                nvm_cmd <= '{valid: cmd_ok, cmd: cmd_req.cmd, addr: cmd_req.addr};
            end
        end
    end
endmodule
`default_nettype wire

/* verif/nvm_pb_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module nvm_pb_chk
    import nvm_access_pkg::*;
#(
    parameter int REGIONS = 16
) (
    input wire logic                          ref_clk,
    input wire logic                          sys_rst,
    input wire nvm_access_pkg::ahb_req_t      ahb_req,
    input wire nvm_access_pkg::ahb_rsp_t      ahb_rsp,
    input wire nvm_access_pkg::nvm_cmd_req_t  cmd_req,
    input wire logic                          debug_chip_erase,
    input wire logic [REGIONS-1:0]            region_lock,
    input wire logic                          main_busy,
    input wire logic                          rww_busy,
    input wire logic                          rww_rd_en,
    input wire logic [31:0]                   rww_rd_data,
    input wire nvm_access_pkg::nvm_cmd_req_t  nvm_cmd,
    input wire logic                          cmd_locked,
    input wire logic                          sys_exception,
    input wire logic [63:0]                   hold_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // accepted transfers and their target window
    wire logic tk = ahb_req.sel && ahb_req.trans[1] && ahb_rsp.ready;
    wire logic rw = ahb_req.addr >= RWW_BASE && ahb_req.addr < RWW_BASE + RWW_SIZE;
    wire logic rd = tk && rw && !ahb_req.write;
    wire logic bw = tk && ahb_req.write && ahb_req.size == HSIZE_BYTE
                    && ahb_req.addr[31:16] == PBUF_BASE[31:16];
    wire logic cv = cmd_req.valid && !debug_chip_erase;
    property p_rst; $fell(sys_rst) |-> hold_data == HOLD_RESET; endproperty
    a_rst: assert property (p_rst) else $error("hold not ones after reset");
    property p_wrd; rd && !main_busy && ahb_req.size == HSIZE_WORD
        |=> !ahb_rsp.ready [*4] ##1 ahb_rsp.ready; endproperty
    a_wrd: assert property (p_wrd) else $error("word read wait wrong");
    property p_sht; rd && !main_busy && ahb_req.size != HSIZE_WORD
        |=> !ahb_rsp.ready [*2] ##1 ahb_rsp.ready; endproperty
    a_sht: assert property (p_sht) else $error("short read wait wrong");
    property p_dat; ahb_rsp.ready && $past(rww_rd_en) && !rww_rd_en
        |-> ahb_rsp.rdata == $past(rww_rd_data); endproperty
    a_dat: assert property (p_dat) else $error("read data not from array");
    property p_bsy; rd && main_busy |=> ahb_rsp.resp && !ahb_rsp.ready && !rww_rd_en
        ##1 ahb_rsp.resp && ahb_rsp.ready; endproperty
    a_bsy: assert property (p_bsy) else $error("read during main busy");
    property p_byt; bw |=> ##[0:1] sys_exception; endproperty
    a_byt: assert property (p_byt) else $error("byte write no exception");
    property p_lck; cv && cmd_req.cmd == CMD_ERASE_ROW && &region_lock
        |=> cmd_locked && !nvm_cmd.valid; endproperty
    a_lck: assert property (p_lck) else $error("locked erase passed");
    property p_chp; debug_chip_erase |=> nvm_cmd.valid && nvm_cmd.cmd == CMD_CHIP_ERA;
    endproperty
    a_chp: assert property (p_chp) else $error("chip erase missing");
    property p_rwe; cv && cmd_req.cmd == CMD_RWW_ERASE && !rww_busy
        |=> nvm_cmd.valid && nvm_cmd.cmd == CMD_RWW_ERASE; endproperty
    a_rwe: assert property (p_rwe) else $error("rww erase not issued");
endmodule
bind nvm_page_buffer_rww_access nvm_pb_chk #(.REGIONS(REGIONS)) u_chk (.ref_clk, .sys_rst,
    .ahb_req, .ahb_rsp, .cmd_req, .debug_chip_erase, .region_lock, .main_busy, .rww_busy,
    .rww_rd_en, .rww_rd_data, .nvm_cmd, .cmd_locked, .sys_exception, .hold_data);
`default_nettype wire

/* verif/rww_array_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rww_array_model (
    input  wire logic        ref_clk,
    input  wire logic        rd_en,
    input  wire logic [31:0] rd_addr,
    output logic      [31:0] rd_data
);
    logic [31:0] junk_q = 32'h0;
    // unselected array shows a changing pattern, never the last word
    always @(posedge ref_clk) begin
        junk_q <= junk_q + 32'h9e37_79b9;
    end
    assign rd_data = rd_en ? {~rd_addr[15:0], rd_addr[15:0]} : junk_q;
endmodule
`default_nettype wire

/* verif/nvm_page_buffer_rww_access_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module nvm_page_buffer_rww_access_tb_top;
    import nvm_access_pkg::*;
    logic ref_clk = 1'h0, sys_rst = 1'h1, debug_chip_erase = 1'h0, main_busy = 1'h0;
    logic [15:0] region_lock = 16'h0;
    logic [2:0]  pbuf_rd_idx = 3'h0;
    logic [31:0] rww_rd_addr, rww_rd_data;
    logic [63:0] pbuf_rd_data, hold;
    logic        rww_rd_en, cmd_locked, sys_exception;
    ahb_req_t     req = '0;
    ahb_rsp_t     rsp;
    nvm_cmd_req_t creq = '0, ncmd;
    int err_total = 0, tests_run = 0, cyc = 0;
    nvm_page_buffer_rww_access uut (.ref_clk, .sys_rst, .ahb_req(req), .ahb_rsp(rsp),
        .cmd_req(creq), .debug_chip_erase, .region_lock, .main_busy, .rww_busy(1'h0),
        .rww_rd_en, .rww_rd_addr, .rww_rd_data, .nvm_cmd(ncmd), .cmd_locked,
        .sys_exception, .pbuf_rd_data, .pbuf_rd_idx, .hold_data(hold));
    rww_array_model u_arr (.ref_clk, .rd_en(rww_rd_en), .rd_addr(rww_rd_addr),
        .rd_data(rww_rd_data));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one transfer: address phase, then data phase until ready
    task automatic ahb(input logic wr, input logic [2:0] sz, input logic [31:0] a, d,
                       output logic [31:0] r, output logic e, output int w);
        @(posedge ref_clk); #1;
        req = '{1'h1, HTRANS_NONSEQ, wr, sz, a, 32'h0};
        @(posedge ref_clk); #1;
        req = '{1'h0, 2'h0, 1'h0, 3'h0, 32'h0, d};
        w = 0;
        // ready is looked at once settled after each edge
        while (rsp.ready !== 1'h1 && w < 20) begin
            w++;
            @(posedge ref_clk); #1;
        end
        r = rsp.rdata;
        e = rsp.resp;
    endtask
    task automatic cmd(input nvm_cmd_t c, input logic [31:0] a, input logic v, lk);
        @(posedge ref_clk); #1;
        creq = '{1'h1, c, a};
        @(posedge ref_clk); #1;
        creq.valid = 1'h0;
        chk(ncmd.valid, v);
        chk(cmd_locked, lk);
        if (v) chk(ncmd.cmd, c);
    endtask
    task automatic t_buf;
        logic [31:0] r; logic e; int w;
        ahb(1'h1, HSIZE_WORD, PBUF_BASE + 32'h4, 32'h2222_2222, r, e, w);
        ahb(1'h1, HSIZE_WORD, PBUF_BASE, 32'h1111_1111, r, e, w);
        ahb(1'h1, HSIZE_HALF, PBUF_BASE + 32'h2, 32'habcd_abcd, r, e, w);
        @(posedge ref_clk); #1;
        chk(hold, 64'h2222_2222_abcd_1111);
        ahb(1'h1, HSIZE_WORD, PBUF_BASE + 32'h14, 32'h3333_3333, r, e, w);
        ahb(1'h1, HSIZE_BYTE, PBUF_BASE + 32'h10, 32'h4444_4444, r, e, w);
        chk(e, 1'h1);
        repeat (2) @(posedge ref_clk); #1;
        chk(hold, 64'h3333_3333_ffff_ffff);
        chk(pbuf_rd_data, 64'h2222_2222_abcd_1111);
        $display("buffer test done");
    endtask
    task automatic t_read;
        logic [31:0] r; logic e; int w;
        ahb(1'h0, HSIZE_BYTE, RWW_BASE + 32'h10, 32'h0, r, e, w);
        chk(r[7:0], 8'h10);
        chk(w, 2);
        ahb(1'h0, HSIZE_HALF, RWW_BASE + 32'h10, 32'h0, r, e, w);
        chk(r[15:0], 16'h0010);
        chk(w, 2);
        ahb(1'h0, HSIZE_WORD, RWW_BASE + 32'h10, 32'h0, r, e, w);
        chk(r, 32'hffef_0010);
        chk(w, 4);
        main_busy = 1'h1;
        ahb(1'h0, HSIZE_WORD, RWW_BASE, 32'h0, r, e, w);
        chk(e, 1'h1);
        main_busy = 1'h0;
        $display("read test done");
    endtask
    task automatic t_cmd;
        cmd(CMD_ERASE_ROW, 32'h100, 1'h1, 1'h0);
        cmd(CMD_RWW_ERASE, RWW_BASE, 1'h1, 1'h0);
        cmd(CMD_WRITE_PG, 32'h100, 1'h1, 1'h0);
        cmd(CMD_RWW_WRITE, RWW_BASE, 1'h1, 1'h0);
        main_busy = 1'h1;
        cmd(CMD_RWW_ERASE, RWW_BASE, 1'h1, 1'h0);
        main_busy = 1'h0;
        region_lock = 16'hffff;
        cmd(CMD_ERASE_ROW, 32'h100, 1'h0, 1'h1);
        cmd(CMD_WRITE_PG, 32'h100, 1'h0, 1'h1);
        region_lock = 16'h0;
        debug_chip_erase = 1'h1;
        @(posedge ref_clk); #1;
        debug_chip_erase = 1'h0;
        chk(ncmd.cmd, CMD_CHIP_ERA);
        $display("command test done");
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'h0;
        chk(hold, HOLD_RESET);
        t_buf;
        t_read;
        t_cmd;
        end_sim;
    end
endmodule
`default_nettype wire
